// [design/pin_sync.sv]
/*
 * Two-flop synchroniser for a group of independent levels.
 * Assumes each bit is a slow level from outside the clk domain;
 * buses that must stay coherent need another scheme.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_s;

    sync_s st;
    sync_s next_st;

    // First stage feeds only the second stage
    always_comb begin
        next_st.first = async_in;
        next_st.second = st.first;
    end

    // State register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= {RESET_VALUE, RESET_VALUE};
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.second;

endmodule

`default_nettype wire

// [design/pmic_i2c_command_port.sv]
/*
 * Two-wire command port of a multi-output power controller: address
 * match, sub-addressed writes into holding latches, commit on STOP,
 * single-byte read-back, status latching and the two-step clear.
 * Assumes SCL/SDA and monitor inputs are asynchronous; SCL is
 * oversampled by clk, so SCL must stay well below clk/8.
 */
`timescale 1ns/1ps
`default_nettype none

module pmic_i2c_command_port #(
    parameter logic [24:0] SHUTDOWN_CYCLES = pmic_i2c_pkg::SHUTDOWN_CYCLES_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Two-wire bus pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Monitors from the analog side
    input wire logic [6:0] output_in_regulation,
    input wire logic input_low_warn,
    input wire logic overheat_warn,
    // Command latches
    output logic [7:0] step_down_1_ctrl,
    output logic [7:0] step_down_2_ctrl,
    output logic [7:0] step_down_3_ctrl,
    output logic [7:0] step_down_4_ctrl,
    output logic [7:0] step_up_ctrl,
    output logic [7:0] step_up_down_ctrl,
    output logic [7:0] led_config,
    output logic [7:0] led_level,
    output logic [7:0] supply_temp_warn_ctrl,
    output logic [7:0] reset_out_mask,
    output logic [7:0] interrupt_out_mask,
    // Derived controls
    output logic led_driver_enable,
    output logic regulators_shutdown,
    output logic reset_out_n,
    output logic interrupt_out_n
);
    import pmic_i2c_pkg::*;

    // Whole port state in one record, registered as one
    typedef struct packed {
        link_state_e state;
        link_state_e after_ack;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic drive_low;
        logic scl_prev;
        logic sda_prev;
        logic sub_seen;
        logic [7:0] last_sub;
        logic clear_armed;
        logic [11:1][7:0] hold;
        logic [11:1][7:0] cmd;
        logic [5:0] pg_latch;
        logic uv_latch;
        logic ot_latch;
        logic irq;
        logic rst_pull;
        logic led_on;
        logic shutdown;
        logic [24:0] timer;
    } port_state_s;

    port_state_s st;
    port_state_s next_st;
    logic [10:0] synced;
    logic scl_s;
    logic sda_s;
    logic [6:0] pg_s;
    logic uv_s;
    logic ot_s;

    // All pins pass two flops before any logic reads them
    // Reset to idle levels: bus released, outputs good, no warnings,
    // so no false edge and no phantom fault gets latched after reset
    pin_sync #(
        .WIDTH(11),
        .RESET_VALUE(11'h7fc)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({scl, sda_in, output_in_regulation, input_low_warn, overheat_warn}),
        .sync_out(synced)
    );

    assign scl_s = synced[10];
    assign sda_s = synced[9];
    assign pg_s = synced[8:2];
    assign uv_s = synced[1];
    assign ot_s = synced[0];

    // Only the command registers take writes
    // Upper nibble set, status or clear offsets all fall outside
    function automatic logic writable(input logic [7:0] sub);
        return sub >= SUB_STEP_DOWN_1 && sub <= SUB_IRQ_MASK;
    endfunction

    // Read-back multiplexer
    function automatic logic [7:0] read_value(input port_state_s s, input logic [6:0] pg);
        logic [7:0] val;
        val = 8'h00;
        if (writable(s.ptr)) begin
            val = s.hold[s.ptr[3:0]];
        end else if (s.ptr == SUB_LIVE_STATUS) begin
            val = {2'b00, pg[5:0]};
        end else if (s.ptr == SUB_LATCHED_STATUS) begin
            val = {s.uv_latch, s.ot_latch, s.pg_latch};
        end
        return val;
    endfunction

    // Next-state logic
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_seen;
        logic stop_seen;
        logic clear_now;
        logic [6:0] fault;
        logic raise;
        logic [7:0] rd_byte;
        next_st = st;
        // Read-back byte, picked once for the first bit and the shifter
        rd_byte = read_value(st, pg_s);
        scl_rise = scl_s & ~st.scl_prev;
        scl_fall = ~scl_s & st.scl_prev;
        start_seen = scl_s & st.scl_prev & st.sda_prev & ~sda_s;
        stop_seen = scl_s & st.scl_prev & ~st.sda_prev & sda_s;
        clear_now = 1'b0;
        fault = ~pg_s;
        raise = (|(fault & st.cmd[SUB_IRQ_MASK[3:0]][6:0])) | uv_s | ot_s;
        next_st.scl_prev = scl_s;
        next_st.sda_prev = sda_s;

        if (start_seen) begin
            // Repeated START keeps holding latches untouched
            next_st.state = LINK_ADDR;
            next_st.cnt = 4'h0;
            next_st.drive_low = 1'b0;
        end else if (stop_seen) begin
            next_st.state = LINK_IDLE;
            next_st.drive_low = 1'b0;
            next_st.cmd = st.hold;
            if (st.hold[SUB_SUPPLY_TEMP[3:0]][RESET_ALL_BIT]) begin
                // Reinitialise: every command register back to default
                for (int i = 1; i <= 11; i++) begin
                    next_st.hold[i] = reg_default(8'(i));
                    next_st.cmd[i] = reg_default(8'(i));
                end
                next_st.shutdown = 1'b1;
                next_st.timer = SHUTDOWN_CYCLES;
            end
            // Two-step clear: 0Fh then 00h, each ended by STOP
            if (st.sub_seen) begin
                if (st.last_sub == SUB_CLEAR) begin
                    next_st.clear_armed = 1'b1;
                end else if (st.last_sub == SUB_NULL && st.clear_armed) begin
                    clear_now = 1'b1;
                    next_st.clear_armed = 1'b0;
                end else begin
                    next_st.clear_armed = 1'b0;
                end
            end
            next_st.sub_seen = 1'b0;
        end else begin
            unique case (st.state)
                LINK_IDLE, LINK_SKIP: begin
                    next_st.drive_low = 1'b0;
                end
                LINK_ADDR, LINK_SUB, LINK_DATA: begin
                    if (scl_rise) begin
                        next_st.shift = {st.shift[6:0], sda_s};
                        next_st.cnt = st.cnt + 4'h1;
                    end else if (scl_fall && st.cnt == BITS_PER_BYTE) begin
                        next_st.cnt = 4'h0;
                        next_st.state = LINK_ACK;
                        next_st.drive_low = 1'b1;
                        unique case (st.state)
                            LINK_ADDR: begin
                                if (st.shift[7:1] != DEV_ADDR) begin
                                    next_st.state = LINK_SKIP;
                                    next_st.drive_low = 1'b0;
                                end else if (st.shift[0]) begin
                                    next_st.after_ack = LINK_SEND;
                                end else begin
                                    next_st.after_ack = LINK_SUB;
                                end
                            end
                            LINK_SUB: begin
                                next_st.ptr = st.shift;
                                next_st.last_sub = st.shift;
                                next_st.sub_seen = 1'b1;
                                next_st.after_ack = LINK_DATA;
                            end
                            default: begin
                                // Data byte lands as its ack begins
                                if (writable(st.ptr)) begin
                                    next_st.hold[st.ptr[3:0]] = st.shift;
                                end
                                next_st.after_ack = LINK_SUB;
                            end
                        endcase
                    end
                end
                LINK_ACK: begin
                    // Release on the falling edge that ends the ack clock
                    if (scl_fall) begin
                        next_st.state = st.after_ack;
                        next_st.drive_low = 1'b0;
                        if (st.after_ack == LINK_SEND) begin
                            next_st.shift = rd_byte;
                            next_st.drive_low = ~rd_byte[7];
                        end
                    end
                end
                LINK_SEND: begin
                    if (scl_fall) begin
                        if (st.cnt == 4'h7) begin
                            // One byte only; master ack is not looked at
                            next_st.state = LINK_SKIP;
                            next_st.drive_low = 1'b0;
                            next_st.cnt = 4'h0;
                        end else begin
                            next_st.cnt = st.cnt + 4'h1;
                            next_st.shift = {st.shift[6:0], 1'b0};
                            next_st.drive_low = ~st.shift[6];
                        end
                    end
                end
                default: begin
                    next_st.state = LINK_IDLE;
                    next_st.drive_low = 1'b0;
                end
            endcase
        end

        // Status latches; a fault present at the clear wins
        if (clear_now) begin
            next_st.pg_latch = fault[5:0];
            next_st.uv_latch = uv_s;
            next_st.ot_latch = ot_s;
            next_st.irq = raise;
        end else begin
            next_st.pg_latch = st.pg_latch | fault[5:0];
            next_st.uv_latch = st.uv_latch | uv_s;
            next_st.ot_latch = st.ot_latch | ot_s;
            next_st.irq = st.irq | raise;
        end

        // Reset pull is not latched
        next_st.rst_pull = |(fault & st.cmd[SUB_RESET_MASK[3:0]][6:0]);
        next_st.led_on = |st.cmd[SUB_LED_LEVEL[3:0]];

        // Reinitialise shutdown window
        // A reinitialise inside the window restarts the count
        if (st.shutdown && !(stop_seen && next_st.timer == SHUTDOWN_CYCLES)) begin
            if (st.timer <= 25'h0000001) begin
                next_st.shutdown = 1'b0;
                next_st.timer = 25'h0000000;
            end else begin
                next_st.timer = st.timer - 25'h0000001;
            end
        end
    end

    // State register; defaults come from the register table
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
            st.scl_prev <= 1'b1;
            st.sda_prev <= 1'b1;
            for (int i = 1; i <= 11; i++) begin
                st.hold[i] <= reg_default(8'(i));
                st.cmd[i] <= reg_default(8'(i));
            end
        end else begin
            st <= next_st;
        end
    end

    // Open-drain SDA: only ever pulled low
    // The pull-up alone makes the high level
    assign sda_out = 1'b0;
    assign sda_oe = st.drive_low;

    // Command latch outputs
    assign step_down_1_ctrl = st.cmd[1];
    assign step_down_2_ctrl = st.cmd[2];
    assign step_down_3_ctrl = st.cmd[3];
    assign step_down_4_ctrl = st.cmd[4];
    assign step_up_ctrl = st.cmd[5];
    assign step_up_down_ctrl = st.cmd[6];
    assign led_config = st.cmd[7];
    assign led_level = st.cmd[8];
    assign supply_temp_warn_ctrl = st.cmd[9];
    assign reset_out_mask = st.cmd[10];
    assign interrupt_out_mask = st.cmd[11];

    // Derived controls, all from flops
    // Reset pull tracks faults unlatched; interrupt holds until cleared
    assign led_driver_enable = st.led_on;
    assign regulators_shutdown = st.shutdown;
    assign reset_out_n = ~st.rst_pull;
    assign interrupt_out_n = ~st.irq;

endmodule

`default_nettype wire

// [design/pmic_i2c_pkg.sv]
/*
 * Shared constants and types for the power-management command port:
 * slave address, sub-addresses, register defaults, field positions,
 * state encoding and the shutdown timing.
 * Assumes a 25 MHz system clock.
 */
package pmic_i2c_pkg;

    // Bus identity and transfer shape
    localparam logic [6:0] DEV_ADDR = 7'h09;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Sub-addresses
    localparam logic [7:0] SUB_NULL = 8'h00;
    localparam logic [7:0] SUB_STEP_DOWN_1 = 8'h01;
    localparam logic [7:0] SUB_STEP_DOWN_4 = 8'h04;
    localparam logic [7:0] SUB_STEP_UP = 8'h05;
    localparam logic [7:0] SUB_STEP_UP_DOWN = 8'h06;
    localparam logic [7:0] SUB_LED_CONFIG = 8'h07;
    localparam logic [7:0] SUB_LED_LEVEL = 8'h08;
    localparam logic [7:0] SUB_SUPPLY_TEMP = 8'h09;
    localparam logic [7:0] SUB_RESET_MASK = 8'h0a;
    localparam logic [7:0] SUB_IRQ_MASK = 8'h0b;
    localparam logic [7:0] SUB_LIVE_STATUS = 8'h0c;
    localparam logic [7:0] SUB_LATCHED_STATUS = 8'h0d;
    localparam logic [7:0] SUB_CLEAR = 8'h0f;

    // Values after reset
    localparam logic [7:0] STEP_DOWN_DEFAULT = 8'h6f;
    localparam logic [7:0] STEP_UP_DEFAULT = 8'h0f;
    localparam logic [7:0] LED_CONFIG_DEFAULT = 8'h0f;
    localparam logic [7:0] LED_LEVEL_DEFAULT = 8'h00;
    localparam logic [7:0] SUPPLY_TEMP_DEFAULT = 8'h00;
    localparam logic [7:0] RESET_MASK_DEFAULT = 8'hff;
    localparam logic [7:0] IRQ_MASK_DEFAULT = 8'h00;

    // Field positions
    localparam int REG_ENABLE_BIT = 7;
    localparam int REG_FLOAT_BIT = 6;
    localparam int REG_MODE_BIT = 5;
    localparam int REG_SLOW_BIT = 4;
    localparam int LED_DOUBLE_FS_BIT = 3;
    localparam int RESET_ALL_BIT = 7;

    // Reinitialise shutdown time
    localparam longint CLK_HZ = 25000000;
    localparam longint SHUTDOWN_TIME_MS = 1000;
    localparam logic [24:0] SHUTDOWN_CYCLES_DEFAULT =
        25'(SHUTDOWN_TIME_MS * CLK_HZ / 1000);

    // Link state machine
    typedef enum logic [2:0] {
        LINK_IDLE = 3'b000,
        LINK_ADDR = 3'b001,
        LINK_SUB = 3'b010,
        LINK_DATA = 3'b011,
        LINK_ACK = 3'b100,
        LINK_SEND = 3'b101,
        LINK_SKIP = 3'b110
    } link_state_e;

    // Default of a command register by sub-address
    function automatic logic [7:0] reg_default(input logic [7:0] sub);
        logic [7:0] val;
        val = 8'h00;
        if (sub >= SUB_STEP_DOWN_1 && sub <= SUB_STEP_DOWN_4) begin
            val = STEP_DOWN_DEFAULT;
        end else begin
            unique case (sub)
                SUB_STEP_UP, SUB_STEP_UP_DOWN: val = STEP_UP_DEFAULT;
                SUB_LED_CONFIG: val = LED_CONFIG_DEFAULT;
                SUB_LED_LEVEL: val = LED_LEVEL_DEFAULT;
                SUB_SUPPLY_TEMP: val = SUPPLY_TEMP_DEFAULT;
                SUB_RESET_MASK: val = RESET_MASK_DEFAULT;
                SUB_IRQ_MASK: val = IRQ_MASK_DEFAULT;
                default: val = 8'h00;
            endcase
        end
        return val;
    endfunction

endpackage

// [tb/i2c_master_model.sv]
/*
 * Behavioural two-wire bus master driving clock and an open-drain pull.
 * Assumes the bench folds pull and the device drive into the wire level.
 */
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
    // System clock and wire level
    input wire logic clk,
    input wire logic sda,
    // Driven lines
    output var logic scl,
    output var logic pull
);
    // Idle bus: clock high, data released
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end

    task automatic t(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Low 5, high 3 clk: device answer lands before the rise
    task automatic bit_io(input logic b, output logic r);
        t(2);
        pull <= ~b;
        t(3);
        scl <= 1'b1;
        t(1);
        r = sda;
        t(2);
        scl <= 1'b0;
    endtask

    // Data falls with clock high; also serves as repeated START
    task automatic start();
        t(2);
        pull <= 1'b0;
        t(3);
        scl <= 1'b1;
        t(3);
        pull <= 1'b1;
        t(3);
        scl <= 1'b0;
    endtask

    // Data rises with clock high, then bus left idle
    task automatic stop();
        t(2);
        pull <= 1'b1;
        t(3);
        scl <= 1'b1;
        t(3);
        pull <= 1'b0;
        t(8);
    endtask

    // MSB first, data released for the device's ack
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, ack);
    endtask

    // Master clocks the ack and pulls low to acknowledge
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(!mack, r);
    endtask
endmodule

`default_nettype wire

// [tb/pmic_i2c_command_port_monitor.sv]
/*
 * Checker for the power controller command port, bound to its top.
 * Assumes the bus pins are seen raw, before the port's synchronisers.
 */
`timescale 1ns/1ps
`default_nettype none

module pmic_i2c_command_port_monitor #(
    parameter logic [24:0] SHUTDOWN_CYCLES = 25'h14
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus pins
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_oe,
    // Monitors
    input wire logic [6:0] output_in_regulation,
    input wire logic input_low_warn,
    input wire logic overheat_warn,
    // Command latches and derived controls
    input wire logic [7:0] step_down_1_ctrl,
    input wire logic [7:0] supply_temp_warn_ctrl,
    input wire logic [7:0] led_level,
    input wire logic [7:0] reset_out_mask,
    input wire logic [7:0] interrupt_out_mask,
    input wire logic led_driver_enable,
    input wire logic regulators_shutdown,
    input wire logic reset_out_n,
    input wire logic interrupt_out_n
);
    logic scl_q;
    logic sda_q;
    logic [3:0] since_stop;
    logic [3:0] since_fault;
    logic [24:0] sd_cnt;
    wire logic stop_now = scl && scl_q && sda_in && !sda_q;
    wire logic fault = |(~output_in_regulation & interrupt_out_mask[6:0])
        | input_low_warn | overheat_warn;

    // Age of the last STOP and fault; saturates so old events stay old
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            since_stop <= 4'hf;
            since_fault <= 4'hf;
            sd_cnt <= 25'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
            since_stop <= stop_now ? 4'h0 : since_stop + {3'h0, since_stop != 4'hf};
            since_fault <= fault ? 4'h0 : since_fault + {3'h0, since_fault != 4'hf};
            sd_cnt <= regulators_shutdown ? sd_cnt + 25'h1 : 25'h0;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_reset_values: assert property ($fell(sys_rst) |-> step_down_1_ctrl == 8'h6f
        && reset_out_mask == 8'hff && interrupt_out_mask == 8'h00 && led_level == 8'h00)
        else $error("command latches not at defaults after reset");
    a_commit_on_stop: assert property ($changed({step_down_1_ctrl, led_level,
        supply_temp_warn_ctrl}) |-> since_stop <= 4'h8)
        else $error("command latch changed without a STOP");
    a_ack_steady: assert property (scl && $past(scl) |-> $stable(sda_oe))
        else $error("data drive changed while clock high");
    a_led_follows: assert property ($stable(led_level)
        |-> led_driver_enable == (led_level != 8'h00))
        else $error("led enable does not follow level");
    a_reset_pass: assert property ((&(output_in_regulation | ~reset_out_mask[6:0]))[*6]
        |-> reset_out_n) else $error("reset output low without masked fault");
    a_reset_fault: assert property ((|(~output_in_regulation & reset_out_mask[6:0]))[*6]
        |-> !reset_out_n) else $error("reset output high with masked fault");
    a_irq_cause: assert property ($fell(interrupt_out_n) |-> since_fault <= 4'h8)
        else $error("interrupt raised without a fault");
    a_irq_clear: assert property ($rose(interrupt_out_n) |-> since_stop <= 4'h8)
        else $error("interrupt released without a STOP");
    a_reinit_defaults: assert property ($rose(regulators_shutdown) |-> ##[0:2]
        (step_down_1_ctrl == 8'h6f && supply_temp_warn_ctrl == 8'h00))
        else $error("reinitialise did not restore defaults");
    a_shutdown_len: assert property ($fell(regulators_shutdown)
        |-> sd_cnt == SHUTDOWN_CYCLES) else $error("shutdown window has wrong length");

    c_stop: cover property (stop_now);
    c_irq: cover property ($fell(interrupt_out_n));
    c_shutdown: cover property ($rose(regulators_shutdown));
endmodule

bind pmic_i2c_command_port pmic_i2c_command_port_monitor #(
    .SHUTDOWN_CYCLES(SHUTDOWN_CYCLES)) u_mon (.*);

`default_nettype wire

// [tb/pmic_i2c_command_port_tb_top.sv]
/*
 * Self-checking bench for the power controller command port.
 * Assumes a short shutdown window and the master model on the bus.
 */
`timescale 1ns/1ps
`default_nettype none

module pmic_i2c_command_port_tb_top;
    import pmic_i2c_pkg::*;
    localparam logic [24:0] SHUT = 25'h14;
    localparam logic [7:0] DEF [1:11] = '{8'h6f, 8'h6f, 8'h6f, 8'h6f, 8'h0f, 8'h0f,
        8'h0f, 8'h00, 8'h00, 8'hff, 8'h00};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [6:0] pg = 7'h7f;
    logic uv = 1'b0;
    logic ot = 1'b0;
    logic scl;
    logic pull;
    logic sda_oe;
    logic sda_drv;
    logic [7:0] cmd [1:11];
    logic led_en;
    logic shutdown;
    logic rst_n;
    logic irq_n;
    int n_fail = 0;
    int n_checks = 0;
    // Open-drain wire with pull-up
    wire logic sda = ~(sda_oe | pull);

    always #20 clk = ~clk;

    pmic_i2c_command_port #(.SHUTDOWN_CYCLES(SHUT)) DUT (
        .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda), .sda_out(sda_drv),
        .sda_oe(sda_oe),
        .output_in_regulation(pg), .input_low_warn(uv), .overheat_warn(ot),
        .step_down_1_ctrl(cmd[1]), .step_down_2_ctrl(cmd[2]), .step_down_3_ctrl(cmd[3]),
        .step_down_4_ctrl(cmd[4]), .step_up_ctrl(cmd[5]), .step_up_down_ctrl(cmd[6]),
        .led_config(cmd[7]), .led_level(cmd[8]), .supply_temp_warn_ctrl(cmd[9]),
        .reset_out_mask(cmd[10]), .interrupt_out_mask(cmd[11]), .led_driver_enable(led_en),
        .regulators_shutdown(shutdown), .reset_out_n(rst_n), .interrupt_out_n(irq_n));
    i2c_master_model m (.clk(clk), .sda(sda), .scl(scl), .pull(pull));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic send(input logic [7:0] b);
        logic a;
        m.wbyte(b, a);
        chk("ack", 8'h00, {7'h00, a});
    endtask

    // Address, sub-address, data, STOP
    task automatic wr(input logic [7:0] sub, input logic [7:0] d);
        m.start();
        send(8'h12);
        send(sub);
        send(d);
        m.stop();
    endtask

    // Pointer set, repeated START, one byte back
    task automatic rd(input logic [7:0] sub, output logic [7:0] d);
        m.start();
        send(8'h12);
        send(sub);
        m.start();
        send(8'h13);
        m.rbyte(1'b1, d);
        m.stop();
    endtask

    task automatic t_defaults();
        logic [7:0] d;
        for (int i = 1; i <= 11; i++) begin
            chk("default", DEF[i], cmd[i]);
        end
        chk("led enable", 8'h00, {7'h00, led_en});
        chk("sda level", 8'h00, {7'h00, sda_drv});
        rd(8'h05, d);
        chk("read step up", 8'h0f, d);
        $display("test defaults done");
    endtask

    // Two pairs under one address; nothing moves before STOP
    task automatic t_multi();
        m.start();
        send(8'h12);
        send(8'h01);
        send(8'ha5);
        send(8'h08);
        send(8'hff);
        repeat (8) @(posedge clk);
        chk("before stop", 8'h6f, cmd[1]);
        m.stop();
        chk("step down 1", 8'ha5, cmd[1]);
        chk("led level", 8'hff, cmd[8]);
        chk("led enable", 8'h01, {7'h00, led_en});
        wr(8'h08, 8'h00);
        chk("led off", 8'h00, {7'h00, led_en});
        $display("test multi done");
    endtask

    // Foreign address, held data, writes that must change nothing
    task automatic t_refuse();
        logic a;
        m.start();
        send(8'h12);
        send(8'h02);
        send(8'h3c);
        m.start();
        m.wbyte(8'h14, a);
        chk("foreign ack", 8'h01, {7'h00, a});
        m.stop();
        chk("held data", 8'h3c, cmd[2]);
        wr(8'h0c, 8'h55);
        wr(8'h0e, 8'h55);
        wr(8'h11, 8'h00);
        chk("unchanged 1", 8'ha5, cmd[1]);
        chk("unchanged 2", 8'h3c, cmd[2]);
        $display("test refuse done");
    endtask

    task automatic t_status();
        logic [7:0] d;
        wr(8'h0b, 8'h01);
        pg <= 7'h7e;
        uv <= 1'b1;
        ot <= 1'b1;
        repeat (8) @(posedge clk);
        chk("irq low", 8'h00, {7'h00, irq_n});
        chk("reset low", 8'h00, {7'h00, rst_n});
        pg <= 7'h7f;
        uv <= 1'b0;
        ot <= 1'b0;
        repeat (8) @(posedge clk);
        chk("reset free", 8'h01, {7'h00, rst_n});
        chk("irq held", 8'h00, {7'h00, irq_n});
        rd(8'h0d, d);
        chk("latched", 8'hc1, d);
        rd(8'h0c, d);
        chk("live", 8'h3f, d);
        m.start();
        send(8'h12);
        send(8'h0f);
        m.stop();
        chk("irq armed", 8'h00, {7'h00, irq_n});
        m.start();
        send(8'h12);
        send(8'h00);
        m.stop();
        chk("irq cleared", 8'h01, {7'h00, irq_n});
        rd(8'h0d, d);
        chk("unlatched", 8'h00, d);
        $display("test status done");
    endtask

    task automatic t_reinit();
        wr(8'h09, 8'h80);
        chk("shutdown on", 8'h01, {7'h00, shutdown});
        chk("restored 1", 8'h6f, cmd[1]);
        chk("restored 9", 8'h00, cmd[9]);
        for (int n = 0; n < 64 && shutdown; n++) begin
            @(posedge clk);
        end
        chk("shutdown off", 8'h00, {7'h00, shutdown});
        $display("test reinit done");
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Reset, then each scenario in turn
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        t_defaults();
        t_multi();
        t_refuse();
        t_status();
        t_reinit();
        end_sim();
    end
endmodule

`default_nettype wire
